/* rtl/cbo_pkg.sv */
/*
 Shared constants and types for the compressed basic-op
 executor. Assumes nothing of its surroundings.
*/
package cbo_pkg;
    // ----------------------------------------
    // Encoding fields
    // ----------------------------------------
    localparam logic [1:0] QUAD_0 = 2'h0;
    localparam logic [1:0] QUAD_1 = 2'h1;
    localparam logic [5:0] F6_LBU = 6'h20;
    localparam logic [5:0] F6_LH = 6'h21;
    localparam logic [5:0] F6_SB = 6'h22;
    localparam logic [5:0] F6_SH = 6'h23;
    localparam logic [5:0] F6_ARITH = 6'h27;
    localparam logic [1:0] F2_MUL = 2'h2;
    localparam logic [4:0] F5_ZEXTB = 5'h18;
    localparam logic [4:0] F5_SEXTB = 5'h19;
    localparam logic [4:0] F5_ZEXTH = 5'h1a;
    localparam logic [4:0] F5_SEXTH = 5'h1b;
    localparam logic [4:0] F5_ZEXTW = 5'h1c;
    localparam logic [4:0] F5_NOT = 5'h1d;
    // Upper index bits of the eight-register subset
    localparam logic [1:0] CREG_HIGH = 2'h1;
    // ----------------------------------------
    // Field positions, sizes, reset values
    // ----------------------------------------
    localparam int BYTE_MSB = 7;
    localparam int HALF_MSB = 15;
    localparam int WORD_MSB = 31;
    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_HALF = 2'h1;
    localparam logic [4:0] REG_RESET = 5'h00;
    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [3:0] {
        OP_NONE, OP_LBU, OP_LHU, OP_LH, OP_SB, OP_SH,
        OP_ZEXTB, OP_SEXTB, OP_ZEXTH, OP_SEXTH,
        OP_ZEXTW, OP_NOT, OP_MUL
    } op_type;
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0, ST_EXEC = 2'h1, ST_MEM = 2'h3, ST_WAIT = 2'h2
    } state_type;
    typedef struct packed {
        op_type op;
        logic legal;
        logic [4:0] dst;
        logic [1:0] offset;
    } decode_type;
endpackage : cbo_pkg

/* rtl/compressed_basic_ops_exec.sv */
/*
 Decode and execution of the twelve simple compressed ops.
 Assumes same-clock register file with combinational read,
 and a memory path returning loaded data in its low bits,
 at least one cycle after the request is taken.
*/
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - c.lbu offset {ins[5],ins[6]}, byte load zero-extended to destination
// - c.lhu offset {ins[5],0}, halfword load zero-extended to destination
// - c.lh uses halfword offset, loaded halfword sign-extended
// - c.sb stores low byte of second source at base plus offset
// - c.sh stores low halfword of second source, offset bit 0 zero
// - Three-bit specifiers select x8 to x15, index is specifier plus eight
// - c.zext.b keeps bits 7..0, clears the rest, writes back
// - c.sext.b copies bit 7 upward, writes back
// - c.zext.h keeps bits 15..0, clears the rest, writes back
// - c.sext.h copies bit 15 upward, writes back
// - c.zext.w, 64-bit only, keeps bits 31..0, clears the rest
// - c.not writes the bitwise complement back
// - c.mul writes low XLEN bits of signed product back
// - c.mul legal only with full multiply or multiply-only subset
// - c.sext.b, c.zext.h, c.sext.h need basic bit-manipulation
// - c.zext.w needs address-generation bit-manipulation
// - c.mul decoded in the compressed arithmetic register format
module compressed_basic_ops_exec #(
    parameter int XLEN = 32,
    parameter bit HAS_M = 1'b1,
    parameter bit HAS_ZMMUL = 1'b0,
    parameter bit HAS_ZBB = 1'b1,
    parameter bit HAS_ZBA = 1'b1
) (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    // Instruction issue
    input wire logic instr_valid,
    input wire logic [15:0] instr,
    output logic instr_ready,
    // Register file read
    output logic [4:0] rf_raddr_a,
    output logic [4:0] rf_raddr_b,
    input wire logic [XLEN-1:0] rf_rdata_a,
    input wire logic [XLEN-1:0] rf_rdata_b,
    // Register write back
    output logic wb_valid,
    output logic [4:0] wb_addr,
    output logic [XLEN-1:0] wb_data,
    // Memory path
    output logic mem_req,
    output logic mem_we,
    output logic [1:0] mem_size,
    output logic [XLEN-1:0] mem_addr,
    output logic [XLEN-1:0] mem_wdata,
    input wire logic mem_ready,
    input wire logic mem_rvalid,
    input wire logic [XLEN-1:0] mem_rdata,
    // Status
    output logic illegal_instr,
    output logic done
);
    import cbo_pkg::*;
    // ----------------------------------------
    // Decode
    // ----------------------------------------
    // Extend from bit msb, signed or not
    function automatic logic [XLEN-1:0] extend(input logic [XLEN-1:0] v, input int msb, input logic sgn);
        logic [XLEN-1:0] r;
        r = '0;
        for (int i = 0; i < XLEN; i++) begin
            r[i] = (i <= msb) ? v[i] : (sgn & v[msb]);
        end
        return r;
    endfunction : extend
    function automatic decode_type decode(input logic [15:0] ins);
        decode_type d;
        d = '0;
        d.op = OP_NONE;
        // Loads write the low specifier, others the high one
        d.dst = {CREG_HIGH, ins[9:7]};
        case ({ins[15:10], ins[1:0]})
            {F6_LBU, QUAD_0}: begin
                d.op = OP_LBU;
                d.dst = {CREG_HIGH, ins[4:2]};
                d.offset = {ins[5], ins[6]};
            end
            {F6_LH, QUAD_0}: begin
                d.op = ins[6] ? OP_LH : OP_LHU;
                d.dst = {CREG_HIGH, ins[4:2]};
                d.offset = {ins[5], 1'b0};
            end
            {F6_SB, QUAD_0}: begin
                d.op = OP_SB;
                d.offset = {ins[5], ins[6]};
            end
            {F6_SH, QUAD_0}: begin
                d.op = ins[6] ? OP_NONE : OP_SH;
                d.offset = {ins[5], 1'b0};
            end
            {F6_ARITH, QUAD_1}: begin
                if (ins[6:5] == F2_MUL) begin
                    d.op = OP_MUL;
                end else begin
                    case (ins[6:2])
                        F5_ZEXTB: d.op = OP_ZEXTB;
                        F5_SEXTB: d.op = OP_SEXTB;
                        F5_ZEXTH: d.op = OP_ZEXTH;
                        F5_SEXTH: d.op = OP_SEXTH;
                        F5_ZEXTW: d.op = OP_ZEXTW;
                        F5_NOT: d.op = OP_NOT;
                        default: d.op = OP_NONE;
                    endcase
                end
            end
            default: d.op = OP_NONE;
        endcase
        // Gate mul, sext.b, zext.h, sext.h and zext.w on the configured extensions; unknown words illegal
        case (d.op)
            OP_NONE: d.legal = 1'b0;
            OP_MUL: d.legal = HAS_M | HAS_ZMMUL;
            OP_SEXTB, OP_ZEXTH, OP_SEXTH: d.legal = HAS_ZBB;
            OP_ZEXTW: d.legal = HAS_ZBA && (XLEN == 64);
            default: d.legal = 1'b1;
        endcase
        return d;
    endfunction : decode
    decode_type dec_in;
    logic accept;
    state_type state, next_state;
    decode_type dec, next_dec;
    logic [XLEN-1:0] opa, next_opa, opb, next_opb;
    logic [XLEN-1:0] alu, load_val;
    logic signed [XLEN-1:0] product;
    // Operands are read in the issue cycle
    assign dec_in = decode(instr);
    assign rf_raddr_a = {CREG_HIGH, instr[9:7]};
    assign rf_raddr_b = {CREG_HIGH, instr[4:2]};
    assign instr_ready = (state == ST_IDLE);
    assign accept = instr_valid && instr_ready && ce;
    // ----------------------------------------
    // Execute
    // ----------------------------------------
    // Low half of the product is sign-agnostic
    assign product = $signed(opa) * $signed(opb);
    // Register-to-register results
    always_comb begin
        case (dec.op)
            OP_ZEXTB: alu = extend(opa, BYTE_MSB, 1'b0);
            OP_SEXTB: alu = extend(opa, BYTE_MSB, 1'b1);
            OP_ZEXTH: alu = extend(opa, HALF_MSB, 1'b0);
            OP_SEXTH: alu = extend(opa, HALF_MSB, 1'b1);
            OP_ZEXTW: alu = extend(opa, WORD_MSB, 1'b0);
            OP_NOT: alu = opa ^ {XLEN{1'b1}};
            OP_MUL: alu = product;
            default: alu = opa;
        endcase
    end
    // Loaded data extension
    always_comb begin
        case (dec.op)
            OP_LBU: load_val = extend(mem_rdata, BYTE_MSB, 1'b0);
            OP_LHU: load_val = extend(mem_rdata, HALF_MSB, 1'b0);
            OP_LH: load_val = extend(mem_rdata, HALF_MSB, 1'b1);
            default: load_val = mem_rdata;
        endcase
    end
    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    logic next_wb_valid, next_mem_req, next_mem_we, next_illegal, next_done;
    logic [4:0] next_wb_addr;
    logic [1:0] next_mem_size;
    logic [XLEN-1:0] next_wb_data, next_mem_addr, next_mem_wdata;
    // One op at a time; issue stalls until it retires
    always_comb begin
        next_state = state;
        next_dec = dec;
        next_opa = opa;
        next_opb = opb;
        next_wb_valid = 1'b0;
        next_wb_addr = wb_addr;
        next_wb_data = wb_data;
        next_mem_req = mem_req;
        next_mem_we = mem_we;
        next_mem_size = mem_size;
        next_mem_addr = mem_addr;
        next_mem_wdata = mem_wdata;
        next_illegal = 1'b0;
        next_done = 1'b0;
        case (state)
            ST_IDLE: begin
                if (instr_valid) begin
                    next_dec = dec_in;
                    next_opa = rf_rdata_a;
                    next_opb = rf_rdata_b;
                    if (!dec_in.legal) begin
                        next_illegal = 1'b1;
                    end else if (dec_in.op inside {OP_LBU, OP_LHU, OP_LH, OP_SB, OP_SH}) begin
                        next_state = ST_MEM;
                        next_mem_req = 1'b1;
                        next_mem_we = dec_in.op inside {OP_SB, OP_SH};
                        next_mem_addr = rf_rdata_a + XLEN'(dec_in.offset);
                        if (dec_in.op inside {OP_LBU, OP_SB}) begin
                            next_mem_size = SIZE_BYTE;
                            next_mem_wdata = extend(rf_rdata_b, BYTE_MSB, 1'b0);
                        end else begin
                            next_mem_size = SIZE_HALF;
                            next_mem_wdata = extend(rf_rdata_b, HALF_MSB, 1'b0);
                        end
                    end else begin
                        next_state = ST_EXEC;
                    end
                end
            end
            ST_EXEC: begin
                next_wb_valid = 1'b1;
                next_wb_addr = dec.dst;
                next_wb_data = alu;
                next_done = 1'b1;
                next_state = ST_IDLE;
            end
            ST_MEM: begin
                if (mem_ready) begin
                    next_mem_req = 1'b0;
                    next_done = mem_we;
                    next_state = mem_we ? ST_IDLE : ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (mem_rvalid) begin
                    next_wb_valid = 1'b1;
                    next_wb_addr = dec.dst;
                    next_wb_data = load_val;
                    next_done = 1'b1;
                    next_state = ST_IDLE;
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end
    // State registers; enable low freezes everything, but reset still clears them
    always_ff @(posedge clk) begin
        if (!rstn) begin
            state <= ST_IDLE;
            dec <= '0;
            opa <= '0;
            opb <= '0;
            wb_valid <= 1'b0;
            wb_addr <= REG_RESET;
            wb_data <= '0;
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            mem_size <= SIZE_BYTE;
            mem_addr <= '0;
            mem_wdata <= '0;
            illegal_instr <= 1'b0;
            done <= 1'b0;
        end else if (ce) begin
            state <= next_state;
            dec <= next_dec;
            opa <= next_opa;
            opb <= next_opb;
            wb_valid <= next_wb_valid;
            wb_addr <= next_wb_addr;
            wb_data <= next_wb_data;
            mem_req <= next_mem_req;
            mem_we <= next_mem_we;
            mem_size <= next_mem_size;
            mem_addr <= next_mem_addr;
            mem_wdata <= next_mem_wdata;
            illegal_instr <= next_illegal;
            done <= next_done;
        end
    end
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // Independent reference values
    logic [XLEN-1:0] exp_addr_b, exp_addr_h;
    logic [7:0] rd_byte, src_byte, opa_byte;
    logic [15:0] rd_half, src_half;
    logic [2*XLEN-1:0] mul_wide;
    assign exp_addr_b = rf_rdata_a + XLEN'({instr[5], instr[6]});
    assign exp_addr_h = rf_rdata_a + XLEN'({instr[5], 1'b0});
    assign rd_byte = mem_rdata[7:0];
    assign rd_half = mem_rdata[15:0];
    assign src_byte = rf_rdata_b[7:0];
    assign src_half = rf_rdata_b[15:0];
    assign opa_byte = opa[7:0];
    assign mul_wide = {{XLEN{opa[XLEN-1]}}, opa} * {{XLEN{opb[XLEN-1]}}, opb};
    sequence s_take(op_type o);
        accept && dec_in.legal && dec_in.op == o;
    endsequence
    sequence s_run(op_type o);
        ce && state == ST_EXEC && dec.op == o;
    endsequence
    sequence s_back(op_type o);
        ce && state == ST_WAIT && mem_rvalid && dec.op == o;
    endsequence
    AST_LBU_ADDR: assert property (s_take(OP_LBU) |=> mem_req && mem_addr == $past(exp_addr_b))
        else $error("byte load address wrong");
    AST_HALF_ADDR: assert property (s_take(OP_LHU) or s_take(OP_LH) or s_take(OP_SH)
        |=> mem_size == SIZE_HALF && mem_addr == $past(exp_addr_h))
        else $error("halfword address wrong");
    AST_LBU_ZEXT: assert property (s_back(OP_LBU) |=> wb_valid && wb_data == XLEN'($past(rd_byte)))
        else $error("byte load not zero-extended");
    AST_LH_SEXT: assert property (s_back(OP_LH)
        |=> wb_valid && wb_data == XLEN'($signed($past(rd_half))))
        else $error("halfword load not sign-extended");
    AST_SB_DATA: assert property (s_take(OP_SB)
        |=> mem_we && mem_size == SIZE_BYTE && mem_wdata == XLEN'($past(src_byte)))
        else $error("byte store data wrong");
    AST_SH_DATA: assert property (s_take(OP_SH) |=> mem_we && mem_wdata == XLEN'($past(src_half)))
        else $error("halfword store data wrong");
    AST_REG_INDEX: assert property (rf_raddr_a[4:3] == CREG_HIGH && rf_raddr_b[4:3] == CREG_HIGH
        && (!wb_valid || wb_addr[4:3] == CREG_HIGH))
        else $error("register outside x8-x15");
    AST_SEXTB: assert property (s_run(OP_SEXTB) |=> wb_data == XLEN'($signed($past(opa_byte))))
        else $error("sign extend byte wrong");
    AST_NOT: assert property (s_run(OP_NOT) |=> wb_valid && wb_data == ~$past(opa))
        else $error("complement wrong");
    AST_MUL: assert property (s_run(OP_MUL) |=> wb_data == $past(mul_wide[XLEN-1:0]))
        else $error("multiply low half wrong");
    AST_PREREQ: assert property (accept && dec_in.op == OP_MUL && !(HAS_M || HAS_ZMMUL)
        |=> illegal_instr)
        else $error("multiply not gated");
    AST_ILLEGAL: assert property (accept && !dec_in.legal
        |=> illegal_instr && !wb_valid && !mem_req && instr_ready ##1 !wb_valid)
        else $error("illegal op executed");
    AST_MEM_HOLD: assert property (mem_req && !mem_ready |=> mem_req && $stable(mem_addr))
        else $error("memory request dropped");
endmodule : compressed_basic_ops_exec
`default_nettype wire

/* tb/cbo_partner.sv */
/*
 Behavioural register file and memory path for the compressed
 op executor. Assumes one shared clock and a synchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none
module cbo_partner #(
    parameter int XLEN = 64
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Register file side
    input wire logic [4:0] rf_raddr_a,
    input wire logic [4:0] rf_raddr_b,
    output logic [XLEN-1:0] rf_rdata_a,
    output logic [XLEN-1:0] rf_rdata_b,
    input wire logic wb_valid,
    input wire logic [4:0] wb_addr,
    input wire logic [XLEN-1:0] wb_data,
    // Memory side
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [1:0] mem_size,
    input wire logic [XLEN-1:0] mem_addr,
    input wire logic [XLEN-1:0] mem_wdata,
    output logic mem_ready,
    output logic mem_rvalid,
    output logic [XLEN-1:0] mem_rdata
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    logic [XLEN-1:0] regs [32];
    logic [7:0] mem [16];
    logic [XLEN-1:0] ld_data, ld_tmp, idle_pat, last_addr, last_wdata;
    logic [1:0] last_size;
    logic last_we, rpend;
    int lat = 0;
    int cnt, rcnt;
    // Combinational read, same cycle
    assign rf_rdata_a = regs[rf_raddr_a];
    assign rf_rdata_b = regs[rf_raddr_b];
    // Idle data toggles so a stale value never matches
    assign mem_rdata = mem_rvalid ? ld_data : idle_pat;
    // ----------------------------------------
    // Write back, memory handshake, load return
    // ----------------------------------------
    always @(posedge clk) begin
        // Upper bits all ones: extension must not lean on them
        ld_tmp = '1;
        ld_tmp[7:0] = mem[mem_addr[3:0]];
        if (mem_size == 2'h1)
            ld_tmp[15:8] = mem[mem_addr[3:0] + 4'h1];
        if (wb_valid)
            regs[wb_addr] <= wb_data;
        mem_rvalid <= 1'b0;
        idle_pat <= ~idle_pat;
        if (!rstn) begin
            mem_ready <= 1'b0;
            cnt <= 0;
            rpend <= 1'b0;
            idle_pat <= {(XLEN/2){2'b01}};
        end else if (mem_req && mem_ready) begin
            mem_ready <= 1'b0;
            cnt <= 0;
            last_addr <= mem_addr;
            last_wdata <= mem_wdata;
            last_we <= mem_we;
            last_size <= mem_size;
            if (mem_we) begin
                mem[mem_addr[3:0]] <= mem_wdata[7:0];
                if (mem_size == 2'h1)
                    mem[mem_addr[3:0] + 4'h1] <= mem_wdata[15:8];
            end else begin
                ld_data <= ld_tmp;
                rpend <= (lat != 0);
                mem_rvalid <= (lat == 0);
                rcnt <= 1;
            end
        end else if (mem_req) begin
            if (cnt >= lat)
                mem_ready <= 1'b1;
            else
                cnt <= cnt + 1;
        end
        // Slow path: data returns lat cycles after the take
        if (rpend && rstn) begin
            if (rcnt >= lat) begin
                mem_rvalid <= 1'b1;
                rpend <= 1'b0;
            end else begin
                rcnt <= rcnt + 1;
            end
        end
    end
endmodule : cbo_partner
`default_nettype wire

/* tb/compressed_basic_ops_exec_bench.sv */
/*
 Self-checking bench for the compressed op executor.
 Assumes the design package and the partner model.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) \
    begin \
        checks++; \
        if ((got) !== (ex)) begin \
            failures++; \
            $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); \
        end \
    end
module compressed_basic_ops_exec_bench;
    import cbo_pkg::*;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic clk, rstn, ce, instr_valid, valid2, instr_ready, wb_valid;
    logic mem_req, mem_we, mem_ready, mem_rvalid, illegal_instr, done, ill2, done2;
    logic ready2, wb_valid2, mem_req2, mem_we2;
    logic [1:0] size2;
    logic [4:0] wb_addr2;
    logic [15:0] instr;
    logic [4:0] rf_raddr_a, rf_raddr_b, wb_addr;
    logic [63:0] rf_rdata_a, rf_rdata_b, wb_data, mem_addr, mem_wdata, mem_rdata;
    logic [1:0] mem_size;
    logic [7:0] bytes [4] = '{8'h81, 8'h9a, 8'he5, 8'h3c};
    int failures, checks;
    // Full configuration, 64-bit so the word extension exists
    compressed_basic_ops_exec #(.XLEN(64)) dut (.clk(clk), .rstn(rstn), .ce(ce),
        .instr_valid(instr_valid), .instr(instr), .instr_ready(instr_ready),
        .rf_raddr_a(rf_raddr_a), .rf_raddr_b(rf_raddr_b), .rf_rdata_a(rf_rdata_a),
        .rf_rdata_b(rf_rdata_b), .wb_valid(wb_valid), .wb_addr(wb_addr), .wb_data(wb_data),
        .mem_req(mem_req), .mem_we(mem_we), .mem_size(mem_size), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_ready(mem_ready), .mem_rvalid(mem_rvalid),
        .mem_rdata(mem_rdata), .illegal_instr(illegal_instr), .done(done));
    // No optional extensions: legality and its side effects are observed here
    compressed_basic_ops_exec #(.XLEN(64), .HAS_M(1'b0), .HAS_ZMMUL(1'b0), .HAS_ZBB(1'b0),
        .HAS_ZBA(1'b0)) dut_bare (.clk(clk), .rstn(rstn), .ce(ce), .instr_valid(valid2),
        .instr(instr), .instr_ready(ready2), .rf_raddr_a(), .rf_raddr_b(), .rf_rdata_a(rf_rdata_a),
        .rf_rdata_b(rf_rdata_b), .wb_valid(wb_valid2), .wb_addr(wb_addr2), .wb_data(),
        .mem_req(mem_req2), .mem_we(mem_we2), .mem_size(size2), .mem_addr(), .mem_wdata(),
        .mem_ready(mem_ready), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata),
        .illegal_instr(ill2), .done(done2));
    cbo_partner #(.XLEN(64)) partner (.clk(clk), .rstn(rstn), .rf_raddr_a(rf_raddr_a),
        .rf_raddr_b(rf_raddr_b), .rf_rdata_a(rf_rdata_a), .rf_rdata_b(rf_rdata_b),
        .wb_valid(wb_valid), .wb_addr(wb_addr), .wb_data(wb_data), .mem_req(mem_req),
        .mem_we(mem_we), .mem_size(mem_size), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_ready(mem_ready), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata));
    // 25 MHz clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic summarize;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : summarize
    // Offer one instruction, wait bounded for retire or refusal
    task automatic issue(input logic sel2, input logic [15:0] ins);
        int n;
        @(posedge clk);
        instr <= ins;
        instr_valid <= !sel2;
        valid2 <= sel2;
        @(posedge clk);
        instr_valid <= 1'b0;
        valid2 <= 1'b0;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (n < 40 && ((sel2 ? (done2 | ill2) : (done | illegal_instr)) !== 1'b1));
        if (n >= 40) begin
            failures++;
            $display("CHECK FAILED retire expected 1 seen timeout");
            summarize();
        end
    endtask : issue
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_unary;
        logic [63:0] v, e;
        int i, k;
        for (k = 0; k < 2; k++) begin
            for (i = 0; i < 6; i++) begin
                // Both polarities of bits 7, 15 and 31
                v = k ? 64'h7fed_cba9_7654_3210 : 64'h8123_4567_89ab_cdef;
                partner.regs[8+i] = v;
                case (i)
                    0: e = {56'h0, v[7:0]};
                    1: e = {{56{v[7]}}, v[7:0]};
                    2: e = {48'h0, v[15:0]};
                    3: e = {{48{v[15]}}, v[15:0]};
                    4: e = {32'h0, v[31:0]};
                    default: e = ~v;
                endcase
                issue(1'b0, {F6_ARITH, 3'(i), F5_ZEXTB + 5'(i), QUAD_1});
                `CHK("unary wb_valid", 1'b1, wb_valid)
                `CHK("unary wb_addr", {2'b01, 3'(i)}, wb_addr)
                `CHK("unary wb_data", e, wb_data)
            end
        end
        $display("test unary done");
    endtask : t_unary
    task automatic t_mul;
        logic signed [127:0] p;
        // Negative operand, then a square issued back to back
        partner.regs[9] = 64'hffff_ffff_ffff_fffd;
        partner.regs[12] = 64'h0000_0001_0000_0005;
        partner.regs[11] = 64'h8000_0000_0000_0003;
        p = $signed(partner.regs[9]) * $signed(partner.regs[12]);
        issue(1'b0, {F6_ARITH, 3'd1, F2_MUL, 3'd4, QUAD_1});
        `CHK("mul wb_addr", 5'd9, wb_addr)
        `CHK("mul wb_data", p[63:0], wb_data)
        p = $signed(partner.regs[11]) * $signed(partner.regs[11]);
        issue(1'b0, {F6_ARITH, 3'd3, F2_MUL, 3'd3, QUAD_1});
        `CHK("square wb_data", p[63:0], wb_data)
        $display("test mul done");
    endtask : t_mul
    task automatic t_load(input int lat);
        logic [63:0] e;
        logic [1:0] off;
        int k;
        partner.lat = lat;
        partner.regs[10] = 64'h1004;
        for (k = 0; k < 8; k++) begin
            // Four byte offsets, then lhu and lh at both halves
            off = (k < 4) ? 2'(k) : {k[0], 1'b0};
            if (k < 4) begin
                e = {56'h0, bytes[off]};
                issue(1'b0, {F6_LBU, 3'd2, off[0], off[1], 3'(k) | 3'd4, QUAD_0});
            end else begin
                e = {48'h0, bytes[off + 2'd1], bytes[off]};
                if (k[1])
                    e[63:16] = {48{e[15]}};
                issue(1'b0, {F6_LH, 3'd2, k[1], off[1], 3'(k) | 3'd4, QUAD_0});
            end
            `CHK("load addr", 64'h1004 + off, partner.last_addr)
            `CHK("load kind", {1'b0, (k < 4) ? SIZE_BYTE : SIZE_HALF}, {partner.last_we, partner.last_size})
            `CHK("load wb_addr", {2'b01, 3'(k) | 3'd4}, wb_addr)
            `CHK("load wb_data", e, wb_data)
        end
        $display("test load done");
    endtask : t_load
    task automatic t_store;
        logic [63:0] e;
        logic [1:0] off;
        logic half;
        int k;
        partner.regs[13] = 64'h1357_9bdf_2468_ace1;
        for (k = 0; k < 6; k++) begin
            half = (k >= 4);
            off = half ? {k[0], 1'b0} : 2'(k);
            e = half ? {48'h0, 16'hace1} : {56'h0, 8'he1};
            issue(1'b0, {half ? F6_SH : F6_SB, 3'd2, half ? 1'b0 : off[0], off[1], 3'd5, QUAD_0});
            `CHK("store addr", 64'h1004 + off, partner.last_addr)
            `CHK("store kind", {1'b1, half ? SIZE_HALF : SIZE_BYTE}, {partner.last_we, partner.last_size})
            `CHK("store wdata", e, partner.last_wdata)
            `CHK("store no write back", 1'b0, wb_valid)
            `CHK("store byte", 8'he1, partner.mem[4'(4 + off)])
        end
        $display("test store done");
    endtask : t_store
    task automatic t_config;
        logic [6:0] bad;
        int i;
        // Bare core: of these seven arithmetic-format ops only zext.b and not remain legal
        bad = 7'b101_1110;
        for (i = 0; i < 7; i++) begin
            if (i < 6)
                issue(1'b1, {F6_ARITH, 3'd0, F5_ZEXTB + 5'(i), QUAD_1});
            else
                issue(1'b1, {F6_ARITH, 3'd0, F2_MUL, 3'd1, QUAD_1});
            `CHK("bare illegal", bad[i], ill2)
            `CHK("bare done", !bad[i], done2)
            `CHK("bare wb", {!bad[i], 5'h08}, {wb_valid2, wb_addr2})
            `CHK("bare mem", 5'b00001, {mem_req2, mem_we2, size2, ready2})
        end
        // Unknown words on the full core, offered back to back
        issue(1'b0, 16'hffff);
        `CHK("unknown illegal", 3'b100, {illegal_instr, mem_req, wb_valid})
        issue(1'b0, 16'h0000);
        `CHK("unknown illegal", 3'b100, {illegal_instr, mem_req, wb_valid})
        $display("test config done");
    endtask : t_config
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        rstn = 1'b0;
        ce = 1'b1;
        instr_valid = 1'b0;
        valid2 = 1'b0;
        instr = 16'h0000;
        failures = 0;
        checks = 0;
        for (int i = 0; i < 4; i++)
            partner.mem[4+i] = bytes[i];
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        @(negedge clk);
        `CHK("reset idle", 4'b1000, {instr_ready, mem_req, done, wb_valid})
        `CHK("reset wb_data", 64'h0, wb_data)
        t_unary();
        t_mul();
        t_load(0);
        t_load(3);
        t_store();
        t_config();
        summarize();
    end
endmodule : compressed_basic_ops_exec_bench
`default_nettype wire
